// [hw/gstmr_pkg.sv]
/*
  Constants, register map and state codes of the gated 16-bit timer.
  Assumes an AXI4-Lite master with 32-bit data; registers sit in the
  low byte of each aligned word.
*/
// Overview of operation
// [R01] Capture event copies count into holding pair
// [R02] Compare flags match of holding pair and count
// [R03] Special event trigger clears the counter
// [R04] Special event clear never sets rollover flag
// [R05] Holding pair acts as period on special events
// [R06] Count byte write beats special event clear
// [R07] Software should use synced instruction clock
// [R08] Source field picks instruction, system, pin, cap
// [R09] Source 10 picks pin or crystal by enable
// [R10] Prescale divides by one, two, four, eight
// [R11] Sync disable only matters for sources 1x
// [R12] On bit gates counting, off clears toggle
// [R13] Gate enable makes counting follow the gate
// [R14] Polarity selects high or low active gate
// [R15] Toggle mode flip-flop flips on gate rise
// [R16] Single-pulse mode places gate under pulse control
// [R17] Go/done reads armed, hardware clears it
// [R18] Gate state bit shows gate level always
// [R19] Gate source picks pin, timer0, comparators
// [R20] Counter mode needs falling edge before rise
// [R21] Single pulse counts once, then self-clears
// [R22] Falling gate state sets gate event flag
// [R23] Rollover from all ones sets rollover flag
// [R24] Count bytes readable and writable separately
// [R25] Count increments on each permitted prescaled tick
package gstmr_pkg;
  localparam int          CNT_W        = 16;
  localparam int          BYTE_W       = 8;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  // Register byte offsets
  localparam logic [7:0]  OFS_TC       = 8'h00;
  localparam logic [7:0]  OFS_GC       = 8'h04;
  localparam logic [7:0]  OFS_CNT_LO   = 8'h08;
  localparam logic [7:0]  OFS_CNT_HI   = 8'h0c;
  localparam logic [7:0]  OFS_CC_LO    = 8'h10;
  localparam logic [7:0]  OFS_CC_HI    = 8'h14;
  localparam logic [7:0]  OFS_CCP_CTRL = 8'h18;
  localparam logic [7:0]  OFS_FLAGS    = 8'h1c;
  // Timer control fields
  localparam int          TC_ON        = 0;
  localparam int          TC_SYNC_DIS  = 2;
  localparam int          TC_OSC_EN    = 3;
  localparam int          TC_PS_LSB    = 4;
  localparam int          TC_CS_LSB    = 6;
  localparam logic [7:0]  TC_RESET     = 8'h00;
  localparam logic [7:0]  TC_WMASK     = 8'hfd;
  // Gate control fields
  localparam int          GC_GSS_LSB   = 0;
  localparam int          GC_VAL       = 2;
  localparam int          GC_GO        = 3;
  localparam int          GC_SPM       = 4;
  localparam int          GC_TM        = 5;
  localparam int          GC_POL       = 6;
  localparam int          GC_GE        = 7;
  localparam logic [7:0]  GC_RESET     = 8'h00;
  // Capture/compare control and flag fields
  localparam int          CC_CAPT      = 0;
  localparam int          CC_CMP       = 1;
  localparam int          CC_SPEC      = 2;
  localparam int          FL_ROLL      = 0;
  localparam int          FL_GATE      = 1;
  // Field codes
  localparam logic [1:0]  CS_INST      = 2'h0;
  localparam logic [1:0]  CS_SYS       = 2'h1;
  localparam logic [1:0]  CS_PIN       = 2'h2;
  localparam logic [1:0]  CS_CAP       = 2'h3;
  localparam logic [1:0]  GSS_PIN      = 2'h0;
  localparam logic [1:0]  GSS_T0       = 2'h1;
  localparam logic [1:0]  GSS_C1       = 2'h2;
  localparam logic [1:0]  GSS_C2       = 2'h3;
  localparam logic [1:0]  INST_LAST    = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // Synchroniser lanes
  localparam int          SI_EXT       = 0;
  localparam int          SI_XTAL      = 1;
  localparam int          SI_CAP       = 2;
  localparam int          SI_GATE      = 3;
  localparam int          SI_C1        = 4;
  localparam int          SI_C2        = 5;
  localparam int          SYNC_N       = 6;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_WAIT = 3'b010,
    SP_RUN  = 3'b100
  } gstmr_sp_t;
endpackage : gstmr_pkg

// [hw/gstmr_top.sv]
/*
  Gated 16-bit timer with prescaler, gate logic and capture/compare
  time base, reached over AXI4-Lite. Assumes every pin and comparator
  input is asynchronous to aclk; timer0 overflow and the capture and
  special-trigger strobes come from logic on aclk.
*/
`timescale 1ns/1ns
module gstmr_top
  import gstmr_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  input  wire logic                external_clock_pin,
  input  wire logic                crystal_in_pin,
  input  wire logic                cap_sense_oscillator,
  input  wire logic                gate_pin,
  input  wire logic                comparator_one_output,
  input  wire logic                comparator_two_output,
  input  wire logic                timer0_overflow,
  input  wire logic                capture_event,
  input  wire logic                special_trigger,
  output logic [CNT_W-1:0]         count_value,
  output logic                     compare_match,
  output logic                     rollover_flag,
  output logic                     gate_event_flag
);
  logic [SYNC_N-1:0]  sync1_reg, sync2_reg, sync3_reg;
  logic [SYNC_N-1:0]  async_in, rise_det, fall_det;
  logic [7:0]         tc_reg, gc_reg, ccp_ctrl_reg;
  logic [CNT_W-1:0]   cnt_reg, cc_reg;
  logic [1:0]         inst_div_reg;
  logic [2:0]         pre_cnt_reg, pre_last;
  logic               aw_hold_reg, w_hold_reg;
  logic [ADDR_W-1:0]  aw_addr_reg;
  logic [7:0]         w_byte_reg;
  logic               w_lane0_reg;
  logic               ext_armed_reg, ext_tick_dly_reg;
  logic               act_prev_reg, tff_reg, lvl_prev_reg, gate_val_reg;
  gstmr_sp_t          sp_state_reg;
  logic               wr_do, wr_hit, wr_tc, wr_gc, wr_lo, wr_hi;
  logic               wr_ccl, wr_cch, wr_ccp, wr_fl, wr_cnt;
  logic               raw_tick, ext_tick, src_tick, cnt_en, inc;
  logic               gate_src, act, lvl, gv, spec_clr, hit;
  logic               on_b, osc_en, sync_dis, ge, pol, tm, spm;
  logic [1:0]         cs, ps, gss;

  assign on_b     = tc_reg[TC_ON];
  assign sync_dis = tc_reg[TC_SYNC_DIS];
  assign osc_en   = tc_reg[TC_OSC_EN];
  assign ps       = tc_reg[TC_PS_LSB +: 2];
  assign cs       = tc_reg[TC_CS_LSB +: 2];
  assign ge       = gc_reg[GC_GE];
  assign pol      = gc_reg[GC_POL];
  assign tm       = gc_reg[GC_TM];
  assign spm      = gc_reg[GC_SPM];
  assign gss      = gc_reg[GC_GSS_LSB +: 2];

  // Two-stage synchronisers, third stage only for edge detection
  assign async_in[SI_EXT]  = external_clock_pin;
  assign async_in[SI_XTAL] = crystal_in_pin;
  assign async_in[SI_CAP]  = cap_sense_oscillator;
  assign async_in[SI_GATE] = gate_pin;
  assign async_in[SI_C1]   = comparator_one_output;
  assign async_in[SI_C2]   = comparator_two_output;
  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          sync3_reg[i] <= 1'b0;
        end
        else
        begin
          sync1_reg[i] <= async_in[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
        end
      end
      assign rise_det[i] = sync2_reg[i] & ~sync3_reg[i];
      assign fall_det[i] = ~sync2_reg[i] & sync3_reg[i];
    end
  endgenerate

  // Write decode; only byte lane 0 carries register data
  assign wr_do  = aw_hold_reg & w_hold_reg & ~bvalid;
  assign wr_hit = wr_do & w_lane0_reg;
  assign wr_tc  = wr_hit & (aw_addr_reg == OFS_TC);
  assign wr_gc  = wr_hit & (aw_addr_reg == OFS_GC);
  assign wr_lo  = wr_hit & (aw_addr_reg == OFS_CNT_LO);
  assign wr_hi  = wr_hit & (aw_addr_reg == OFS_CNT_HI);
  assign wr_ccl = wr_hit & (aw_addr_reg == OFS_CC_LO);
  assign wr_cch = wr_hit & (aw_addr_reg == OFS_CC_HI);
  assign wr_ccp = wr_hit & (aw_addr_reg == OFS_CCP_CTRL);
  assign wr_fl  = wr_hit & (aw_addr_reg == OFS_FLAGS);
  assign wr_cnt = wr_lo | wr_hi;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFS_TC) || (a == OFS_GC) || (a == OFS_CNT_LO) ||
              (a == OFS_CNT_HI) || (a == OFS_CC_LO) ||
              (a == OFS_CC_HI) || (a == OFS_CCP_CTRL) ||
              (a == OFS_FLAGS);
  endfunction : addr_ok

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready     <= 1'b0;
      wready      <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg  <= '0;
      w_lane0_reg <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready     <= 1'b0;
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (!aw_hold_reg && !bvalid)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        wready      <= 1'b0;
        w_hold_reg  <= 1'b1;
        w_byte_reg  <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      else if (!w_hold_reg && !bvalid)
        wready <= 1'b1;
      if (wr_do)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        OFS_TC:       rdata <= {24'h000000, tc_reg};
        OFS_GC:       rdata <= {24'h000000, gc_reg[7:4],
                                (sp_state_reg != SP_IDLE), gate_val_reg,
                                gc_reg[1:0]}; // R17 R18
        OFS_CNT_LO:   rdata <= {24'h000000, cnt_reg[7:0]}; // R24
        OFS_CNT_HI:   rdata <= {24'h000000, cnt_reg[15:8]}; // R24
        OFS_CC_LO:    rdata <= {24'h000000, cc_reg[7:0]};
        OFS_CC_HI:    rdata <= {24'h000000, cc_reg[15:8]};
        OFS_CCP_CTRL: rdata <= {24'h000000, ccp_ctrl_reg};
        OFS_FLAGS:    rdata <= {30'h00000000, gate_event_flag,
                                rollover_flag};
        default:      rdata <= '0;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // Control registers; unimplemented timer bit reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tc_reg       <= TC_RESET;
      ccp_ctrl_reg <= 8'h00;
    end
    else
    begin
      if (wr_tc)
        tc_reg <= w_byte_reg & TC_WMASK;
      if (wr_ccp)
        ccp_ctrl_reg <= w_byte_reg & 8'h07;
    end
  end

  // Gate control; go/done mirrors the pulse machine, state bit is live
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gc_reg <= GC_RESET;
    else if (wr_gc)
      gc_reg <= {w_byte_reg[7:4], 1'b0, 1'b0, w_byte_reg[1:0]};
  end

  // Clock source selection and synchronisation option
  assign ext_tick = osc_en ? rise_det[SI_XTAL] // R09
                           : (rise_det[SI_EXT] & ext_armed_reg); // R20
  always_comb
  begin
    unique case (cs) // R08
      CS_INST: raw_tick = (inst_div_reg == INST_LAST);
      CS_SYS:  raw_tick = 1'b1;
      CS_PIN:  raw_tick = ext_tick;
      default: raw_tick = rise_det[SI_CAP];
    endcase
  end
  // Synchronised mode retimes the external tick one more aclk stage
  assign src_tick = (cs[1] && !sync_dis) ? ext_tick_dly_reg // R11
                  : (cs == CS_PIN) ? ext_tick : raw_tick; // R11

  // Instruction clock divider and external arming
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inst_div_reg     <= 2'h0;
      ext_armed_reg    <= 1'b0;
      ext_tick_dly_reg <= 1'b0;
    end
    else
    begin
      inst_div_reg     <= inst_div_reg + 2'h1;
      ext_tick_dly_reg <= (cs == CS_PIN) ? ext_tick : rise_det[SI_CAP];
      if (!on_b || osc_en)
        ext_armed_reg <= 1'b0;
      else if (fall_det[SI_EXT])
        ext_armed_reg <= 1'b1; // R20
    end
  end

  // Gate path: source, polarity, toggle, single pulse
  always_comb
  begin
    unique case (gss) // R19
      GSS_PIN: gate_src = sync2_reg[SI_GATE];
      GSS_T0:  gate_src = timer0_overflow;
      GSS_C1:  gate_src = sync2_reg[SI_C1];
      default: gate_src = sync2_reg[SI_C2];
    endcase
  end
  assign act = pol ? gate_src : ~gate_src; // R14
  assign lvl = tm ? tff_reg : act; // R15
  assign gv  = spm ? ((sp_state_reg == SP_RUN) & lvl) : lvl; // R16

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_prev_reg <= 1'b0;
      tff_reg      <= 1'b0;
      lvl_prev_reg <= 1'b0;
      gate_val_reg <= 1'b0;
    end
    else
    begin
      act_prev_reg <= act;
      lvl_prev_reg <= lvl;
      gate_val_reg <= gv; // R18
      if (!tm || !on_b)
        tff_reg <= 1'b0; // R12 R15
      else if (act && !act_prev_reg)
        tff_reg <= ~tff_reg; // R15
    end
  end

  // Single-pulse machine; idle means go/done reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sp_state_reg <= SP_IDLE;
    else if (!spm || (wr_gc && !w_byte_reg[GC_SPM]))
      sp_state_reg <= SP_IDLE; // R17
    else if (wr_gc)
      sp_state_reg <= w_byte_reg[GC_GO] ? SP_WAIT : SP_IDLE;
    else
    begin
      unique case (sp_state_reg)
        SP_IDLE: sp_state_reg <= SP_IDLE;
        SP_WAIT: if (lvl && !lvl_prev_reg)
                   sp_state_reg <= SP_RUN; // R21
        SP_RUN:  if (!lvl && lvl_prev_reg)
                   sp_state_reg <= SP_IDLE; // R21
      endcase
    end
  end

  // Count permission, prescaler and special event clear
  assign cnt_en   = on_b & (~ge | gate_val_reg); // R12 R13
  assign pre_last = 3'((4'h1 << ps) - 4'h1); // R10
  assign inc      = cnt_en & src_tick & (pre_cnt_reg == pre_last); // R25
  assign hit      = (cnt_reg == cc_reg);
  assign spec_clr = special_trigger // R03
                  | (ccp_ctrl_reg[CC_SPEC] & ccp_ctrl_reg[CC_CMP] & hit);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_cnt_reg <= 3'h0;
    else if (wr_cnt || wr_tc || !on_b)
      pre_cnt_reg <= 3'h0;
    else if (cnt_en && src_tick)
      pre_cnt_reg <= (pre_cnt_reg == pre_last) ? 3'h0
                                               : pre_cnt_reg + 3'h1; // R10
  end

  // Counter: byte write beats special clear beats increment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (wr_lo)
      cnt_reg[7:0] <= w_byte_reg; // R06 R24
    else if (wr_hi)
      cnt_reg[15:8] <= w_byte_reg; // R06 R24
    else if (spec_clr)
      cnt_reg <= '0; // R03 R05
    else if (inc)
      cnt_reg <= cnt_reg + 16'h0001; // R25
  end

  // Holding pair: capture from hardware wins over a bus write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cc_reg <= '0;
    else if (capture_event && ccp_ctrl_reg[CC_CAPT])
      cc_reg <= cnt_reg; // R01
    else if (wr_ccl)
      cc_reg[7:0] <= w_byte_reg;
    else if (wr_cch)
      cc_reg[15:8] <= w_byte_reg;
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rollover_flag   <= 1'b0;
      gate_event_flag <= 1'b0;
      compare_match   <= 1'b0;
      count_value     <= '0;
    end
    else
    begin
      count_value   <= cnt_reg;
      compare_match <= ccp_ctrl_reg[CC_CMP] & hit; // R02
      if (inc && !spec_clr && !wr_cnt && (cnt_reg == 16'hffff))
        rollover_flag <= 1'b1; // R04 R23
      else if (wr_fl && w_byte_reg[FL_ROLL])
        rollover_flag <= 1'b0;
      if (gate_val_reg && !gv)
        gate_event_flag <= 1'b1; // R22
      else if (wr_fl && w_byte_reg[FL_GATE])
        gate_event_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_capture;
    capture_event && ccp_ctrl_reg[CC_CAPT] |=> cc_reg == $past(cnt_reg);
  endproperty
  a_capture: assert property (p_capture) // R01
    else $error("capture did not copy the count");
  property p_compare;
    ccp_ctrl_reg[CC_CMP] && cnt_reg == cc_reg |=> compare_match;
  endproperty
  a_compare: assert property (p_compare) // R02
    else $error("compare match not raised");
  property p_spec_clear;
    special_trigger && !wr_cnt |=> cnt_reg == 16'h0000;
  endproperty
  a_spec_clear: assert property (p_spec_clear) // R03
    else $error("special trigger did not clear count");
  property p_spec_no_roll;
    spec_clr && !rollover_flag |=> !rollover_flag;
  endproperty
  a_spec_no_roll: assert property (p_spec_no_roll) // R04
    else $error("special clear set rollover flag");
  property p_write_wins;
    wr_lo && spec_clr |=> cnt_reg[7:0] == $past(w_byte_reg);
  endproperty
  a_write_wins: assert property (p_write_wins) // R06
    else $error("special clear beat the count write");
  property p_off_holds;
    !on_b && !wr_cnt && !spec_clr |=> $stable(cnt_reg) && !tff_reg;
  endproperty
  a_off_holds: assert property (p_off_holds) // R12
    else $error("counter moved or toggle set while off");
  property p_toggle_clear;
    !tm ##1 !tm |-> !tff_reg;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) // R15
    else $error("toggle flip-flop not held clear");
  property p_go_clear;
    !spm |=> sp_state_reg == SP_IDLE;
  endproperty
  a_go_clear: assert property (p_go_clear) // R17
    else $error("go/done not cleared without single pulse");
  property p_gate_event;
    gate_val_reg && !gv |=> gate_event_flag;
  endproperty
  a_gate_event: assert property (p_gate_event) // R22
    else $error("gate falling edge did not set flag");
  property p_rollover;
    inc && !spec_clr && !wr_cnt && cnt_reg == 16'hffff
      |=> rollover_flag && cnt_reg == 16'h0000;
  endproperty
  a_rollover: assert property (p_rollover) // R23
    else $error("rollover not flagged");
  property p_increment;
    inc && !spec_clr && !wr_cnt |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment) // R25
    else $error("count did not step by one");

  c_roll:    cover property (inc && cnt_reg == 16'hffff);
  c_capture: cover property (capture_event && ccp_ctrl_reg[CC_CAPT]);
  c_spm:     cover property (sp_state_reg == SP_RUN ##1
                             sp_state_reg == SP_IDLE);
  c_gate:    cover property (gate_val_reg && !gv);
endmodule : gstmr_top

// [tb/gstmr_partner.sv]
/*
  Far-side model: timer clock pins, gate sources and capture strobes.
  Assumes the bench commands it on rising edges of aclk.
*/
`timescale 1ns/1ns
module gstmr_partner (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [3:0] npulse,
  input  wire logic [3:0] gsrc,
  input  wire logic       cap_go,
  input  wire logic       spec_on,
  output logic            external_clock_pin,
  output logic            crystal_in_pin,
  output logic            cap_sense_oscillator,
  output logic            gate_pin,
  output logic            timer0_overflow,
  output logic            comparator_one_output,
  output logic            comparator_two_output,
  output logic            capture_event,
  output logic            special_trigger
);
  logic [3:0] left_reg = 4'h0;
  logic [2:0] ph_reg   = 3'h0;
  logic       ck;
  // Burst of rises, four cycles low then four high; clocks idle low
  always_ff @(posedge aclk)
  begin
    if (go)
      left_reg <= npulse;
    else if (left_reg != 4'h0)
    begin
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h7)
        left_reg <= left_reg - 4'h1;
    end
  end
  assign ck = (left_reg != 4'h0) & ph_reg[2];
  assign external_clock_pin   = ck;
  assign crystal_in_pin       = ck;
  assign cap_sense_oscillator = ck;
  // Gate sources are plain levels set by the bench
  assign {comparator_two_output, comparator_one_output} = gsrc[3:2];
  assign {timer0_overflow, gate_pin} = gsrc[1:0];
  // One-cycle capture strobe; special trigger is a held level
  always_ff @(posedge aclk)
    capture_event <= cap_go;
  assign special_trigger = spec_on;
endmodule : gstmr_partner

// [tb/gstmr_top_test.sv]
/*
  Self-checking bench of the gated timer: AXI4-Lite tasks and directed
  scenarios. Assumes the far-side model gstmr_partner.
*/
`timescale 1ns/1ns
module gstmr_top_test;
  import gstmr_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, go = 0, cap_go = 0, spec_on = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  gsrc = 0, npulse = 0;
  logic [1:0]  bresp, rresp;
  logic [15:0] count_value, c0, mx;
  // Timer settings of the counted bursts: pin sync/async, crystal, cap
  logic [7:0]  tcv [5] = '{8'h81, 8'h85, 8'h89, 8'hc1, 8'hc5};
  logic awready, wready, bvalid, arready, rvalid, compare_match;
  logic rollover_flag, gate_event_flag, external_clock_pin;
  logic crystal_in_pin, cap_sense_oscillator, gate_pin, timer0_overflow;
  logic comparator_one_output, comparator_two_output;
  logic capture_event, special_trigger;
  int n_errors = 0, checks_done = 0, n;

  always #20 aclk = ~aclk;

  gstmr_top gstmr_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .external_clock_pin, .crystal_in_pin,
    .cap_sense_oscillator, .gate_pin, .comparator_one_output,
    .comparator_two_output, .timer0_overflow, .capture_event,
    .special_trigger, .count_value, .compare_match, .rollover_flag,
    .gate_event_flag);

  gstmr_partner gstmr_partner_inst (.aclk, .go, .npulse, .gsrc, .cap_go,
    .spec_on, .external_clock_pin, .crystal_in_pin, .cap_sense_oscillator,
    .gate_pin, .timer0_overflow, .comparator_one_output,
    .comparator_two_output, .capture_event, .special_trigger);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // A handshake that never comes ends the run as a mismatch
  task automatic tmo;
    if (n >= 80)
    begin
      n_errors++;
      end_sim();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    n = 0;
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= {24'h0, d};
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 80);
    bready <= 1'b0;
    tmo();
    chk(bresp, er);
    @(posedge aclk);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er = RESP_OKAY);
    n = 0;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 80);
    rready <= 1'b0;
    tmo();
    chk(rdata, {24'h0, e});
    chk(rresp, er);
    @(posedge aclk);
  endtask : rc

  task automatic tk(input int k);
    repeat (k) @(posedge aclk);
  endtask : tk

  // Gate pin pulse long enough to pass the input synchronisers
  task automatic gp;
    gsrc <= 4'h1; tk(6); gsrc <= 4'h0; tk(6);
  endtask : gp

  initial
  begin
    tk(2); aresetn <= 1'b1; tk(1);
    rc(OFS_TC, 8'h00);
    // Low polarity with the gate pin low: gate state already active
    rc(OFS_GC, 8'h04);
    rc(8'h20, 8'h00, RESP_SLVERR);
    wr(8'h20, 8'hff, RESP_SLVERR);
    // Counted clock bursts: pin needs a falling edge before counting
    foreach (tcv[i])
    begin
      wr(OFS_TC, 8'h00); wr(OFS_CNT_LO, 8'h00);
      wr(OFS_TC, tcv[i]);
      npulse <= 4'h5; go <= 1'b1; tk(1); go <= 1'b0; tk(60);
      rc(OFS_CNT_LO, (i < 2) ? 8'h04 : 8'h05);
    end
    // Increment rate over 32 cycles for both internal clocks
    for (int cs = 0; cs < 2; cs++)
      for (int ps = 0; ps < 4; ps++)
      begin
        wr(OFS_TC, {cs[1:0], ps[1:0], 4'h1});
        c0 = count_value; n = 0;
        while (count_value === c0 && n < 80) begin tk(1); n++; end
        tmo(); c0 = count_value; tk(32);
        chk(count_value - c0, (cs ? 32 : 8) >> ps);
      end
    wr(OFS_TC, 8'h00); c0 = count_value; tk(8);
    chk(count_value, c0);
    wr(OFS_CNT_LO, 8'hfd); wr(OFS_CNT_HI, 8'hff); wr(OFS_TC, 8'h41); tk(8);
    chk(rollover_flag, 1);
    wr(OFS_TC, 8'h00); wr(OFS_FLAGS, 8'h01);
    chk(rollover_flag, 0);
    // Held special trigger keeps the count at zero, no rollover
    spec_on <= 1'b1; wr(OFS_CNT_LO, 8'hff); wr(OFS_CNT_HI, 8'hff);
    wr(OFS_TC, 8'h41); tk(8);
    chk(count_value, 0);
    chk(rollover_flag, 0);
    spec_on <= 1'b0; wr(OFS_TC, 8'h00);
    wr(OFS_CNT_LO, 8'h34); wr(OFS_CNT_HI, 8'h12); wr(OFS_CCP_CTRL, 8'h01);
    cap_go <= 1'b1; tk(1); cap_go <= 1'b0; tk(4);
    rc(OFS_CC_LO, 8'h34);
    rc(OFS_CC_HI, 8'h12);
    wr(OFS_CCP_CTRL, 8'h02); tk(3);
    chk(compare_match, 1);
    wr(OFS_CNT_LO, 8'h35); tk(3);
    chk(compare_match, 0);
    wr(OFS_CNT_HI, 8'h00); wr(OFS_CNT_LO, 8'h00); wr(OFS_CC_LO, 8'h03);
    wr(OFS_CC_HI, 8'h00); wr(OFS_CCP_CTRL, 8'h06);
    wr(OFS_TC, 8'h01);
    mx = 0;
    repeat (60) begin tk(1); if (count_value > mx) mx = count_value; end
    chk(mx, 3);
    wr(OFS_CCP_CTRL, 8'h00); wr(OFS_TC, 8'h41);
    // Gate enable, polarity, state and event flag
    wr(OFS_GC, 8'hc0); tk(6); c0 = count_value; tk(8);
    chk(count_value, c0);
    rc(OFS_GC, 8'hc0);
    gsrc <= 4'h1; tk(8);
    rc(OFS_GC, 8'hc4);
    chk(count_value == c0, 0);
    // Polarity change above already raised the flag; clear it first
    wr(OFS_FLAGS, 8'h02);
    chk(gate_event_flag, 0);
    gsrc <= 4'h0; tk(8);
    chk(gate_event_flag, 1);
    wr(OFS_GC, 8'h80);
    rc(OFS_GC, 8'h84);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_GC, 8'hc0 | i[7:0]); gsrc <= 4'h1 << i; tk(8);
      rc(OFS_GC, 8'hc4 | i[7:0]);
      gsrc <= 4'h0; tk(1);
    end
    wr(OFS_GC, 8'he0); gp();
    rc(OFS_GC, 8'he4);
    gp();
    rc(OFS_GC, 8'he0);
    // Single-pulse mode must be on before go/done can be armed
    wr(OFS_GC, 8'hd0); wr(OFS_GC, 8'hd8);
    rc(OFS_GC, 8'hd8);
    gp();
    rc(OFS_GC, 8'hd0);
    c0 = count_value; gp();
    chk(count_value, c0);
    wr(OFS_GC, 8'hd8); wr(OFS_GC, 8'hc8);
    rc(OFS_GC, 8'hc0);
    end_sim();
  end
endmodule : gstmr_top_test
